//--- hw/lfs_link_if.sv
/*
 Link between the sequencer and one multi-cell filter.
 Assumes both ends share sys_clk; the shared data input is resolved here.
*/
`timescale 1ns/10ps
interface lfs_link_if;
    logic en;                                  // Filter advances this edge
    logic [lfs_pkg::DATA_W-1:0] f1_data;       // New-sample FIFO output
    logic f1_oe;                               // New-sample FIFO drives
    logic [lfs_pkg::DATA_W-1:0] f2_data;       // Re-feed FIFO output
    logic f2_oe;                               // Re-feed FIFO drives
    logic [lfs_pkg::DATA_W-1:0] din;           // Resolved data input
    logic [lfs_pkg::BYTE_W-1:0] coef;          // Coefficient byte
    logic coef_first;                          // Marks first tap
    logic coef_last;                           // Marks last tap
    logic coeff_signedness_select;             // High: coefficient unsigned
    logic [lfs_pkg::ACC_W-1:0] sum;            // Sum output bus
    logic sum_valid;                           // Sum holds a result

    // Shared data input; the driving FIFO wins, else the bus reads zero
    assign din = f2_oe ? f2_data : (f1_oe ? f1_data : '0);

    modport ctl (
        output en, f1_data, f1_oe, f2_data, f2_oe, coef, coef_first,
        output coef_last, coeff_signedness_select,
        input sum, sum_valid
    );
    modport flt (
        input en, din, coef, coef_first, coef_last,
        input coeff_signedness_select,
        output sum, sum_valid
    );
endinterface : lfs_link_if

//--- hw/lfs_mac_cell.sv
/*
 One multiply-accumulate cell of the filter device.
 Assumes the coefficient and tap markers arrive one cell stage delayed.
*/
`timescale 1ns/10ps
module lfs_mac_cell
    import lfs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic [DATA_W-1:0] din,
    input wire logic [BYTE_W-1:0] coef_in,
    input wire logic first_in,
    input wire logic last_in,
    input wire logic coeff_signedness_select,
    output logic [BYTE_W-1:0] coef_out,
    output logic first_out,
    output logic last_out,
    output logic hit,
    output logic [ACC_W-1:0] result
);
    typedef struct packed {
        logic [BYTE_W-1:0] coef; // Coefficient passed to next cell
        logic first;             // First-tap marker passed on
        logic last;              // Last-tap marker passed on
        logic [ACC_W-1:0] acc;   // Running sum
    } lfs_cell_s;

    lfs_cell_s cell_reg;
    lfs_cell_s cell_next;
    logic signed [BYTE_W:0] c_ext;          // Coefficient with sign bit
    logic signed [BYTE_W+DATA_W:0] p_full;  // Exact product
    logic [PROD_W-1:0] prod;                // Partial product
    logic [ACC_W-1:0] prod_ext;             // Product widened to sum

    // Multiply and accumulate; first tap restarts the sum
    always_comb
    begin
        c_ext = $signed({coeff_signedness_select ? 1'b0 : coef_in[BYTE_W-1],
                         coef_in});
        p_full = c_ext * $signed(din);
        prod = p_full[PROD_W-1:0];
        prod_ext = {{(ACC_W-PROD_W){prod[PROD_W-1]}}, prod};
        cell_next.coef = coef_in;
        cell_next.first = first_in;
        cell_next.last = last_in;
        if (first_in)
            cell_next.acc = prod_ext;
        else
            cell_next.acc = cell_reg.acc + prod_ext;
    end

    // State register, frozen while disabled
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            cell_reg <= '0;
        else if (ce)
            cell_reg <= cell_next;
    end

    assign coef_out = cell_reg.coef;
    assign first_out = cell_reg.first;
    assign last_out = cell_reg.last;
    assign hit = ce && last_in;
    assign result = cell_next.acc;
endmodule : lfs_mac_cell

//--- hw/lfs_multi_cell_filter.sv
/*
 Multi-cell multiply-accumulate filter device with its output adder.
 Assumes the sequencer presents data, coefficients and markers per edge.
*/
`timescale 1ns/10ps
module lfs_multi_cell_filter
    import lfs_pkg::*;
#(
    parameter int CELLS = DEF_CELLS
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic shift_add_combine,
    lfs_link_if.flt lnk
);
    typedef struct packed {
        logic [ACC_W-1:0] sum;  // Output bus
        logic valid;            // Output holds a result
        logic [ACC_W-1:0] held; // Last raw result for shift-and-add
    } lfs_flt_s;

    lfs_flt_s flt_reg;
    lfs_flt_s flt_next;
    logic run;                                  // Cells advance
    logic [CELLS:0][BYTE_W-1:0] ch_coef;        // Coefficient chain
    logic [CELLS:0] ch_first;                   // First marker chain
    logic [CELLS:0] ch_last;                    // Last marker chain
    logic [CELLS-1:0] hits;                     // Cell finishing
    logic [CELLS-1:0][ACC_W-1:0] results;       // Cell results
    logic [ACC_W-1:0] res;                      // Finishing cell result

    assign run = ce && lnk.en;
    assign ch_coef[0] = lnk.coef;
    assign ch_first[0] = lnk.coef_first;
    assign ch_last[0] = lnk.coef_last;

    // Coefficients shift one cell per edge; data is broadcast
    for (genvar k = 0; k < CELLS; k++)
    begin : g_cell
        lfs_mac_cell u_cell (
            .sys_clk(sys_clk),
            .resetn(resetn),
            .ce(run),
            .din(lnk.din),
            .coef_in(ch_coef[k]),
            .first_in(ch_first[k]),
            .last_in(ch_last[k]),
            .coeff_signedness_select(lnk.coeff_signedness_select),
            .coef_out(ch_coef[k+1]),
            .first_out(ch_first[k+1]),
            .last_out(ch_last[k+1]),
            .hit(hits[k]),
            .result(results[k])
        );
    end

    // Output adder: one finishing cell per edge, optional shift-and-add
    always_comb
    begin
        res = '0;
        for (int k = 0; k < CELLS; k++)
        begin
            if (hits[k])
                res = res | results[k];
        end
        flt_next = flt_reg;
        flt_next.valid = |hits;
        if (|hits)
        begin
            flt_next.held = res;
            if (shift_add_combine)
                flt_next.sum = {res[ACC_W-1-BYTE_SHIFT:0],
                                {BYTE_SHIFT{1'b0}}} + flt_reg.held;
            else
                flt_next.sum = res;
        end
    end

    // Output register, frozen with the cells
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            flt_reg <= '0;
        else if (run)
            flt_reg <= flt_next;
    end

    assign lnk.sum = flt_reg.sum;
    assign lnk.sum_valid = flt_reg.valid;
endmodule : lfs_multi_cell_filter

//--- hw/lfs_pkg.sv
/*
 Shared constants for the long FIR data sequencer and its filter device.
 Assumes one 25 MHz clock (sys_clk) and an active-low asynchronous reset.
*/
// How it works
// - Filter outputs N-sample blocks, L-1 idle cycles between
// - Each block takes L+N-1 clocks, one sample each
// - Results collected in last N clocks of period
// - Flush N-1 clocks, then re-feed last L-1 samples
// - Eight-bit block counter wraps modulo L+N-1
// - Init: L-1 samples via FIFO1 to FIFO2
// - Per period: L-1 from FIFO2, then N from FIFO1
// - Write last L-1 fed back to FIFO2
// - Only selected FIFO enables its shared data output
// - Coefficients: L taps then N-1 zeros per period
// - Optional output FIFO smooths bursty result blocks
// - Split coefficient bytes; high product weighted 2^8
// - Cells form 16-bit products, 26-bit sums
// - Lower partial sum sign-extended beyond 26 bits
// - Low coefficient byte treated as unsigned
// - Two filters in parallel, external adder combines
// - Shift-and-add output adder combines cell sums
// - 26-bit sum bus, 34-bit full combined result
// - Combiner picks a 16-bit result window
// - Cells finish on successive clocks, one per clock
package lfs_pkg;
    localparam int DATA_W = 8;        // Sample width
    localparam int BYTE_W = 8;        // Coefficient byte per filter
    localparam int COEF_W = 16;       // Wide coefficient width
    localparam int PROD_W = 16;       // Cell partial product
    localparam int ACC_W = 26;        // Sum output bus width
    localparam int FULL_W = 34;       // Full combined result
    localparam int OUT_W = 16;        // Result window width
    localparam int CNT_W = 8;         // Block counter width
    localparam int BYTE_SHIFT = 8;    // Weight 2^8 of the high byte
    localparam int DEF_TAPS = 8;      // Default tap count L
    localparam int DEF_CELLS = 4;     // Default cell count N
    localparam int DEF_F1_DEPTH = 8;  // Default new-sample FIFO depth
    localparam int DEF_OUT_DEPTH = 8; // Default output FIFO depth
    localparam int DEF_WIN_LSB = 8;   // Default window low bit
    localparam int OF_MARGIN = 2;     // Output FIFO room kept free
    typedef enum logic {LFS_INIT, LFS_RUN} lfs_state_e;
endpackage : lfs_pkg

//--- hw/lfs_sequencer.sv
/*
 Sequencer and combiner driving a low-byte and a high-byte filter.
 Assumes both filters share sys_clk and see the same data stream.
*/
`timescale 1ns/10ps
module lfs_sequencer
    import lfs_pkg::*;
#(
    parameter int TAPS = DEF_TAPS,
    parameter int CELLS = DEF_CELLS,
    parameter int F1_DEPTH = DEF_F1_DEPTH,
    parameter int OUT_DEPTH = DEF_OUT_DEPTH,
    parameter int WIN_LSB = DEF_WIN_LSB
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic in_valid,
    input wire logic [DATA_W-1:0] in_data,
    output logic in_ready,
    input wire logic coef_wr,
    input wire logic [CNT_W-1:0] coef_addr,
    input wire logic [COEF_W-1:0] coef_wdata,
    output logic out_valid,
    output logic [OUT_W-1:0] out_data,
    input wire logic out_ready,
    lfs_link_if.ctl flt_lo,
    lfs_link_if.ctl flt_hi
);
    localparam int PERIOD = TAPS + CELLS - 1;
    localparam int F2_DEPTH = TAPS - 1;
    localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(PERIOD - 1);
    localparam logic [CNT_W-1:0] TAP_LAST = CNT_W'(TAPS - 1);
    localparam logic [CNT_W-1:0] WB_FIRST = CNT_W'(CELLS);
    localparam logic [CNT_W-1:0] F1_FULL = CNT_W'(F1_DEPTH);
    localparam logic [CNT_W-1:0] F2_FULL = CNT_W'(F2_DEPTH);
    localparam logic [CNT_W-1:0] OF_FULL = CNT_W'(OUT_DEPTH);
    localparam logic [CNT_W-1:0] OF_LIMIT = CNT_W'(OUT_DEPTH - OF_MARGIN);

    typedef struct packed {
        lfs_state_e st;                         // Init or steady state
        logic [CNT_W-1:0] cnt;                  // Block counter
        logic [F1_DEPTH-1:0][DATA_W-1:0] f1;    // New-sample FIFO
        logic [CNT_W-1:0] f1_wp;
        logic [CNT_W-1:0] f1_rp;
        logic [CNT_W-1:0] f1_n;
        logic [F2_DEPTH-1:0][DATA_W-1:0] f2;    // Re-feed FIFO
        logic [CNT_W-1:0] f2_wp;
        logic [CNT_W-1:0] f2_rp;
        logic [CNT_W-1:0] f2_n;
        logic [TAPS-1:0][COEF_W-1:0] cmem;      // Coefficient store
        logic en;                               // Filters advance
        logic en_prev;                          // Enable one cycle back
        logic f1_oe;                            // FIFO1 drives data
        logic f2_oe;                            // FIFO2 drives data
        logic [DATA_W-1:0] dat;                 // Presented sample
        logic [COEF_W-1:0] coef;                // Presented coefficient
        logic first;                            // First-tap marker
        logic last;                             // Last-tap marker
        logic [OUT_DEPTH-1:0][OUT_W-1:0] of;    // Output rate FIFO
        logic [CNT_W-1:0] of_wp;
        logic [CNT_W-1:0] of_rp;
        logic [CNT_W-1:0] of_n;
        logic ready;                            // Input ready
        logic ovalid;                           // Output word valid
        logic [OUT_W-1:0] odata;                // Output word
    } lfs_seq_s;

    lfs_seq_s s_reg;
    lfs_seq_s s_next;
    logic push1, pop1, push2, pop2, push_o, pop_o;
    logic [DATA_W-1:0] fed;                     // Sample sent to filters
    logic [CNT_W-1:0] cidx;                     // Coefficient index
    logic [FULL_W-1:0] hi_ext;                  // High partial sum widened
    logic [FULL_W-1:0] lo_ext;                  // Low partial sum widened
    logic [FULL_W-1:0] full;                    // Full combined result

    // Circular pointer step
    function automatic logic [CNT_W-1:0] lfs_step(
        input logic [CNT_W-1:0] p,
        input int depth
    );
        return (int'(p) == depth - 1) ? '0 : p + 1'b1;
    endfunction : lfs_step

    // Sequencing, FIFO bookkeeping, combining and output buffering
    always_comb
    begin
        s_next = s_reg;
        push1 = in_valid && s_reg.ready;
        pop1 = 1'b0;
        pop2 = 1'b0;
        push2 = 1'b0;
        fed = '0;
        cidx = TAP_LAST - s_reg.cnt;
        s_next.en = 1'b0;
        s_next.f1_oe = 1'b0;
        s_next.f2_oe = 1'b0;
        s_next.first = 1'b0;
        s_next.last = 1'b0;
        s_next.coef = '0;
        s_next.en_prev = s_reg.en;
        unique case (s_reg.st)
            LFS_INIT:
            begin
                // Pass the first samples straight into the re-feed FIFO
                if (s_reg.f1_n != '0)
                begin
                    pop1 = 1'b1;
                    push2 = 1'b1;
                    fed = s_reg.f1[s_reg.f1_rp];
                    if (s_reg.f2_n == F2_FULL - 1'b1)
                        s_next.st = LFS_RUN;
                end
            end
            LFS_RUN:
            begin
                // Stall when new samples or output room are missing
                if (!((s_reg.cnt >= TAP_LAST && s_reg.f1_n == '0) ||
                      s_reg.of_n >= OF_LIMIT))
                begin
                    s_next.en = 1'b1;
                    if (s_reg.cnt < TAP_LAST)
                    begin
                        pop2 = 1'b1;
                        s_next.f2_oe = 1'b1;
                        fed = s_reg.f2[s_reg.f2_rp];
                    end
                    else
                    begin
                        pop1 = 1'b1;
                        s_next.f1_oe = 1'b1;
                        fed = s_reg.f1[s_reg.f1_rp];
                    end
                    if (s_reg.cnt <= TAP_LAST)
                        s_next.coef = s_reg.cmem[cidx];
                    s_next.first = (s_reg.cnt == '0);
                    s_next.last = (s_reg.cnt == TAP_LAST);
                    push2 = (s_reg.cnt >= WB_FIRST);
                    if (s_reg.cnt == LAST_CNT)
                        s_next.cnt = '0;
                    else
                        s_next.cnt = s_reg.cnt + 1'b1;
                end
            end
        endcase
        s_next.dat = s_next.en ? fed : s_reg.dat;

        // New-sample FIFO, loaded in both states whenever ready
        if (push1)
        begin
            s_next.f1[s_reg.f1_wp] = in_data;
            s_next.f1_wp = lfs_step(s_reg.f1_wp, F1_DEPTH);
        end
        if (pop1)
            s_next.f1_rp = lfs_step(s_reg.f1_rp, F1_DEPTH);
        s_next.f1_n = s_reg.f1_n + {{(CNT_W-1){1'b0}}, push1}
                      - {{(CNT_W-1){1'b0}}, pop1};
        s_next.ready = (s_next.f1_n != F1_FULL);

        // Re-feed FIFO
        if (push2)
        begin
            s_next.f2[s_reg.f2_wp] = fed;
            s_next.f2_wp = lfs_step(s_reg.f2_wp, F2_DEPTH);
        end
        if (pop2)
            s_next.f2_rp = lfs_step(s_reg.f2_rp, F2_DEPTH);
        s_next.f2_n = s_reg.f2_n + {{(CNT_W-1){1'b0}}, push2}
                      - {{(CNT_W-1){1'b0}}, pop2};

        // Coefficient store write port
        if (coef_wr && int'(coef_addr) < TAPS)
            s_next.cmem[coef_addr] = coef_wdata;

        // Recombine partial sums: high weighted 2^8, both sign-extended
        hi_ext = {{(FULL_W-ACC_W){flt_hi.sum[ACC_W-1]}}, flt_hi.sum};
        lo_ext = {{(FULL_W-ACC_W){flt_lo.sum[ACC_W-1]}}, flt_lo.sum};
        full = {hi_ext[FULL_W-1-BYTE_SHIFT:0], {BYTE_SHIFT{1'b0}}}
               + lo_ext;
        push_o = s_reg.en_prev && flt_lo.sum_valid
                 && s_reg.of_n != OF_FULL;
        if (push_o)
        begin
            s_next.of[s_reg.of_wp] = full[WIN_LSB +: OUT_W];
            s_next.of_wp = lfs_step(s_reg.of_wp, OUT_DEPTH);
        end

        // Output register drains the rate FIFO
        pop_o = 1'b0;
        if ((!s_reg.ovalid || out_ready) && s_reg.of_n != '0)
        begin
            pop_o = 1'b1;
            s_next.odata = s_reg.of[s_reg.of_rp];
            s_next.ovalid = 1'b1;
            s_next.of_rp = lfs_step(s_reg.of_rp, OUT_DEPTH);
        end
        else if (out_ready)
            s_next.ovalid = 1'b0;
        s_next.of_n = s_reg.of_n + {{(CNT_W-1){1'b0}}, push_o}
                      - {{(CNT_W-1){1'b0}}, pop_o};
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            s_reg <= '0;
        else if (ce)
            s_reg <= s_next;
    end

    assign in_ready = s_reg.ready;
    assign out_valid = s_reg.ovalid;
    assign out_data = s_reg.odata;

    // Both filters see the same samples; bytes of the coefficient split
    assign flt_lo.en = s_reg.en;
    assign flt_lo.f1_data = s_reg.dat;
    assign flt_lo.f1_oe = s_reg.f1_oe;
    assign flt_lo.f2_data = s_reg.dat;
    assign flt_lo.f2_oe = s_reg.f2_oe;
    assign flt_lo.coef = s_reg.coef[BYTE_W-1:0];
    assign flt_lo.coef_first = s_reg.first;
    assign flt_lo.coef_last = s_reg.last;
    assign flt_lo.coeff_signedness_select = 1'b1;
    assign flt_hi.en = s_reg.en;
    assign flt_hi.f1_data = s_reg.dat;
    assign flt_hi.f1_oe = s_reg.f1_oe;
    assign flt_hi.f2_data = s_reg.dat;
    assign flt_hi.f2_oe = s_reg.f2_oe;
    assign flt_hi.coef = s_reg.coef[COEF_W-1:BYTE_W];
    assign flt_hi.coef_first = s_reg.first;
    assign flt_hi.coef_last = s_reg.last;
    assign flt_hi.coeff_signedness_select = 1'b0;
endmodule : lfs_sequencer

//--- testbench/lfs_link_props.sv
/*
 Concurrent checks on one sequencer-to-filter link.
 Assumes the low-byte link signals, sys_clk and resetn as plain inputs.
*/
`timescale 1ns/10ps
module lfs_link_props
    import lfs_pkg::*;
#(
    parameter int TAPS = DEF_TAPS,
    parameter int CELLS = DEF_CELLS
)
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic en,
    input wire logic f1_oe,
    input wire logic f2_oe,
    input wire logic [BYTE_W-1:0] coef,
    input wire logic coef_first,
    input wire logic coef_last,
    input wire logic coeff_signedness_select,
    input wire logic sum_valid
);
    localparam int PER = TAPS + CELLS - 1; // Cycles in one block period
    // Helper state: presentations since the period began
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic started;
    } lfs_chk_s;
    lfs_chk_s st_reg;
    lfs_chk_s st_next;
    logic [CNT_W-1:0] idx; // Position of the current presentation
    // Next helper state; a first-tap marker restarts the position
    always_comb
    begin
        idx = coef_first ? '0 : st_reg.cnt;
        st_next = st_reg;
        // Frozen cycles present nothing new, so the position holds
        if (en && ce)
        begin
            st_next.cnt = CNT_W'(idx + 1);
            st_next.started = 1'b1;
        end
    end
    // Register the helper state
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end
    default clocking dclk @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);
    property p_oe_excl;
        !(f1_oe && f2_oe);
    endproperty
    a_oe_excl: assert property (p_oe_excl)
        else $error("both fifo outputs enabled");
    property p_idx_range;
        en |-> idx < PER;
    endproperty
    a_idx_range: assert property (p_idx_range)
        else $error("period longer than expected");
    property p_wrap;
        en && coef_first && st_reg.started |-> st_reg.cnt == PER;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("period restarted at wrong count");
    property p_last_pos;
        en && coef_last |-> idx == TAPS - 1;
    endproperty
    a_last_pos: assert property (p_last_pos)
        else $error("last tap marker misplaced");
    property p_f2_sel;
        en && idx < TAPS - 1 |-> f2_oe && !f1_oe;
    endproperty
    a_f2_sel: assert property (p_f2_sel)
        else $error("refeed fifo not selected");
    property p_f1_sel;
        en && idx >= TAPS - 1 |-> f1_oe && !f2_oe;
    endproperty
    a_f1_sel: assert property (p_f1_sel)
        else $error("new sample fifo not selected");
    property p_zero_pad;
        en && idx >= TAPS |-> coef == '0;
    endproperty
    a_zero_pad: assert property (p_zero_pad)
        else $error("padding coefficient not zero");
    property p_lo_unsigned;
        en |-> coeff_signedness_select;
    endproperty
    a_lo_unsigned: assert property (p_lo_unsigned)
        else $error("low byte not unsigned");
    property p_block_len;
        $rose(sum_valid) |-> sum_valid [*4];
    endproperty
    a_block_len: assert property (p_block_len)
        else $error("result block too short");
    property p_block_gap;
        $fell(sum_valid) |-> !sum_valid [*7];
    endproperty
    a_block_gap: assert property (p_block_gap)
        else $error("gap between blocks too short");
    c_wrap: cover property (en && coef_first && st_reg.started);
    c_block: cover property ($rose(sum_valid));
    c_f1: cover property (en && f1_oe);
endmodule : lfs_link_props

//--- testbench/test_long_fir_data_sequencer.sv
/*
 Testbench: sequencer driving a low-byte and a high-byte filter.
 Assumes the package, link interface and link checker compile first.
*/
`timescale 1ns/10ps
module test_long_fir_data_sequencer
    import lfs_pkg::*;
;
    localparam int TAPS = DEF_TAPS; // Tap count L
    localparam int CELLS = DEF_CELLS; // Cell count N
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1; // Clock enable, dropped to freeze
    logic in_valid = 1'b0;
    logic [DATA_W-1:0] in_data = '0;
    logic coef_wr = 1'b0;
    logic [CNT_W-1:0] coef_addr = '0;
    logic [COEF_W-1:0] coef_wdata = '0;
    logic out_ready = 1'b0;
    logic in_ready;
    logic out_valid;
    logic [OUT_W-1:0] out_data;
    int errors = 0;
    int n_checks = 0;
    int n_out = 0; // Results received so far
    int coefs [TAPS]; // Wide coefficients as loaded
    int hist [$]; // Every sample sent, in order
    // 25 MHz clock
    always #20 sys_clk = ~sys_clk;
    lfs_link_if lnk_lo();
    lfs_link_if lnk_hi();
    lfs_sequencer #(.TAPS(TAPS), .CELLS(CELLS)) lfs_sequencer_i (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce),
        .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
        .coef_wr(coef_wr), .coef_addr(coef_addr), .coef_wdata(coef_wdata),
        .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
        .flt_lo(lnk_lo), .flt_hi(lnk_hi));
    lfs_multi_cell_filter #(.CELLS(CELLS)) lfs_multi_cell_filter_lo_i (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce),
        .shift_add_combine(1'b0), .lnk(lnk_lo));
    lfs_multi_cell_filter #(.CELLS(CELLS)) lfs_multi_cell_filter_hi_i (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce),
        .shift_add_combine(1'b0), .lnk(lnk_hi));
    lfs_link_props #(.TAPS(TAPS), .CELLS(CELLS)) lfs_link_props_i (
        .sys_clk(sys_clk), .resetn(resetn), .ce(ce), .en(lnk_lo.en),
        .f1_oe(lnk_lo.f1_oe), .f2_oe(lnk_lo.f2_oe), .coef(lnk_lo.coef),
        .coef_first(lnk_lo.coef_first), .coef_last(lnk_lo.coef_last),
        .coeff_signedness_select(lnk_lo.coeff_signedness_select),
        .sum_valid(lnk_lo.sum_valid));
    // Count a comparison and report a mismatch
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1)
        begin
            errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask : chk
    // Print the counts and the verdict, then stop
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    // Full-precision FIR result, windowed to the output width
    function automatic logic [OUT_W-1:0] exp_word(input int n);
        longint acc;
        acc = 0;
        for (int i = 0; i < TAPS; i++)
            acc += longint'(coefs[i]) * hist[n - i];
        return acc[DEF_WIN_LSB +: OUT_W];
    endfunction : exp_word
    // Sample pattern with frequent full-scale negatives
    function automatic int smp(input int k);
        return (k % 5 == 0) ? -128 : ((k * 73 + 5) % 256) - 128;
    endfunction : smp
    // One coefficient write; caller drops coef_wr
    task automatic write_coef(input int a, input int v);
        coef_wr = 1'b1;
        coef_addr = a[CNT_W-1:0];
        coef_wdata = v[COEF_W-1:0];
        @(posedge sys_clk);
        #1;
    endtask : write_coef
    // Offer one sample and hold it until taken
    task automatic send(input int v);
        logic t;
        int w;
        in_valid = 1'b1;
        in_data = v[DATA_W-1:0];
        hist.push_back(v);
        t = 1'b0;
        for (w = 0; w < 300 && !t; w++)
        begin
            @(posedge sys_clk);
            t = in_ready === 1'b1 && ce === 1'b1;
            #1;
        end
        if (!t)
            chk(1'b0, "sample never taken");
    endtask : send
    // Collect cnt results after holding off for pause cycles
    task automatic recv(input int cnt, input int pause);
        logic t;
        logic [OUT_W-1:0] d;
        int got;
        got = 0;
        repeat (pause)
        begin
            @(posedge sys_clk);
            #1;
        end
        out_ready = 1'b1;
        for (int w = 0; w < 3000 && got < cnt; w++)
        begin
            @(posedge sys_clk);
            t = out_valid === 1'b1 && ce === 1'b1;
            d = out_data;
            #1;
            if (t)
            begin
                chk(d === exp_word(TAPS - 1 + n_out), "result word");
                n_out++;
                got++;
            end
        end
        chk(got == cnt, "result count");
        out_ready = 1'b0;
    endtask : recv
    // Stream ns samples, expect as many results as no, optional freeze of ce
    task automatic stream(input int ns, input int no, input int pause,
                          input logic frz);
        fork
            begin
                for (int k = 0; k < ns; k++)
                    send(smp(hist.size()));
                in_valid = 1'b0;
            end
            recv(no, pause);
            if (frz)
            begin
                repeat (3) @(posedge sys_clk);
                #1 ce = 1'b0;
                repeat (6) @(posedge sys_clk);
                #1 ce = 1'b1;
            end
        join
    endtask : stream
    // Cut a hang short
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        chk(1'b0, "run timed out");
        print_verdict();
    end
    // Main sequence
    initial
    begin
        coefs = '{-32768, 32767, 4736, -300, 255, -1, 32640, 341};
        repeat (6) @(posedge sys_clk);
        chk(in_ready === 1'b0 && out_valid === 1'b0, "reset outputs");
        #1 resetn = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        chk(in_ready === 1'b1, "ready after reset");
        $display("test reset done");
        for (int a = 0; a < TAPS; a++)
            write_coef(a, coefs[a]);
        write_coef(TAPS, 16'h5a5a); // Unmapped tap index is ignored
        coef_wr = 1'b0;
        $display("test coefficients done");
        stream(TAPS - 1 + 6 * CELLS, 6 * CELLS, 0, 1'b0);
        $display("test full rate done");
        stream(4 * CELLS, 4 * CELLS, 30, 1'b1);
        $display("test backpressure done");
        stream(2 * CELLS, 2 * CELLS, 0, 1'b0);
        $display("test continuation done");
        print_verdict();
    end
endmodule : test_long_fir_data_sequencer
